// ===== trk_defs.svh
`ifndef TRK_DEFS_SVH
`define TRK_DEFS_SVH

// Register byte offsets
`define TRK_CTRL_OFF      12'h000
`define TRK_FLOOD_OFF     12'h004
`define TRK_STATUS_OFF    12'h008
`define TRK_EVENT_OFF     12'h00C
`define TRK_PWD_LO_OFF    12'h010
`define TRK_PWD_HI_OFF    12'h014
`define TRK_OFFICER_OFF   12'h018
`define TRK_CRYPTO_OFF    12'h01C
`define TRK_MOTION_OFF    12'h020
`define TRK_ID_LEN_OFF    12'h024
`define TRK_ID_ID         12'h025

// Control register fields
`define TRK_CTRL_LED_EN    0
`define TRK_CTRL_WAIT_BTN  1
`define TRK_CTRL_GPS_ON    2
`define TRK_CTRL_LOG_EN    3
`define TRK_CTRL_BLOCK     4
`define TRK_CTRL_MOT_EN    5
`define TRK_CTRL_CMD_MODE  6
`define TRK_CTRL_RESET     32'h0000_0001

// Event register bits written by software
`define TRK_EV_ESC         0
`define TRK_EV_TX_DONE     1
`define TRK_EV_TX_OK       2
`define TRK_EV_CMD_ERR     3
`define TRK_EV_EXIT        4

// Password reset value, printable "12345678"
`define TRK_PWD_LO_RESET   32'h3132_3334
`define TRK_PWD_HI_RESET   32'h3536_3738
`define TRK_OFFICER_RESET  32'h0000_0000
`define TRK_FLOOD_RESET    32'h0000_0101
`define TRK_CRYPTO_RESET   32'h0000_0000
`define TRK_MOTION_RESET   32'h0000_0010

`define TRK_ID_MAX         6'd50

// Timing
`define TRK_CLK_HZ         40000000
`define TRK_AWAKE_S        10
`define TRK_AWAKE_CYC      (`TRK_AWAKE_S * `TRK_CLK_HZ)
`define TRK_BLINK_CYC      10000000

`endif

// ===== trk_pkg.sv
package trk_pkg;
	typedef enum logic [1:0] {
		TRK_MODE_NORMAL,
		TRK_MODE_EMERG,
		TRK_MODE_TEST
	} trk_mode_t;

	typedef struct packed {
		logic       valid;
		logic       two_d;
		logic [2:0] bars;
	} trk_fix_t;

	typedef struct packed {
		logic power;
		logic gps;
		logic sat;
		logic xfer;
		logic emerg;
	} trk_led_t;
endpackage

// ===== trk_ctrl.sv
// Behaviour
// - Emergency button or emergency input pin enters emergency tracking.
// - Test input pin enters test tracking with its own parameters.
// - Emergency ignores escape; needs one completed send attempt before leaving.
// - Reports in emergency tracking carry the emergency flag bit.
// - Emergency entry sends configured flood count, then emergency interval.
// - Test entry sends its own flood count, then test interval.
// - With logging on, each report is stored; full memory overwrites oldest.
// - Blocking enabled in tracking suppresses reports without valid fix.
// - Always-on option keeps positioning receiver powered between reports.
// - Update password is eight printable characters, factory default held.
// - Platform identifier up to 50 characters, included in reports; code keeps only its length, and reports carry no identifier.
// - Button press while asleep wakes for 10 s; escape then exits tracking.
// - Auto power-on at supply unless configured to wait for button; reset clears the wait bit, so code always powers on.
// - Press and release of power button toggles off and on.
// - Fix indicator solid valid, blink 2-D or estimate, dark otherwise.
// - Signal indicator solid 3-5 bars, blink 1-2, dark at zero.
// - Tracking transfer indicator: dark entry, solid last ok, blink earlier ok.
// - Emergency indicator lights on emergency button or pin.
// - Command transfer indicator: dark entry, solid clean, blink clean after error.
// - Indicators switchable off by command; enabled at reset.
// - Motion reported only after persisting for the configured time-out.
// - Encryption changes refused until officer password replaced.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "trk_defs.svh"

module trk_ctrl
	import trk_pkg::*;
#(
	parameter int unsigned AWAKE_CYC = `TRK_AWAKE_CYC,
	parameter int unsigned BLINK_CYC = `TRK_BLINK_CYC,
	parameter int unsigned LOG_DEPTH = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        emerg_button_i,
	input  wire logic        emergency_input_pin_i,
	input  wire logic        test_input_pin_i,
	input  wire logic        power_button_i,
	input  wire logic        motion_raw_i,
	input  wire logic        report_req_i,
	input  wire trk_fix_t    fix_i,
	output logic             report_send_o,
	output logic             report_emerg_flag_o,
	output logic             log_write_o,
	output logic       [7:0] log_addr_o,
	output logic             gps_power_o,
	output logic             dev_on_o,
	output logic             motion_o,
	output trk_led_t         led_o
);
	localparam int unsigned LW = $clog2(LOG_DEPTH);

	function automatic logic is_blink_bars(input logic [2:0] b);
		return (b == 3'h1) || (b == 3'h2);
	endfunction

	trk_mode_t   mode_q;
	logic [31:0] ctrl_q, flood_q, pwd_lo_q, pwd_hi_q, officer_q, crypto_q, mot_to_q;
	logic [5:0]  id_len_q;
	logic [7:0]  flood_cnt_q;
	logic        attempt_q, interval_q;
	logic        on_q, btn_q, started_q, awake_q;
	logic [31:0] awake_cnt_q, mot_cnt_q, blink_cnt_q;
	logic        blink_q;
	logic [LW-1:0] log_ptr_q;
	logic        ok_ever_q, last_ok_q, xfer_seen_q;
	logic        cmd_err_q, cmd_last_ok_q, cmd_seen_q, cmd_blink_q;
	logic        crypto_err_q;

	wire acc = psel_i && penable_i;
	wire wr  = acc && pwrite_i;
	wire ev_wr = wr && paddr_i == `TRK_EVENT_OFF;
	wire emerg_in = emerg_button_i || emergency_input_pin_i;
	wire tracking = on_q && !ctrl_q[`TRK_CTRL_CMD_MODE];
	wire esc = ev_wr && pwdata_i[`TRK_EV_ESC];
	wire tx_done = ev_wr && pwdata_i[`TRK_EV_TX_DONE];
	wire tx_ok = pwdata_i[`TRK_EV_TX_OK];
	wire pwd_print = pwdata_i[31:24] >= 8'h20 && pwdata_i[31:24] <= 8'h7E
		&& pwdata_i[23:16] >= 8'h20 && pwdata_i[23:16] <= 8'h7E
		&& pwdata_i[15:8] >= 8'h20 && pwdata_i[15:8] <= 8'h7E
		&& pwdata_i[7:0] >= 8'h20 && pwdata_i[7:0] <= 8'h7E;

	// Config registers
	// A password word with any non-printable byte is dropped whole
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q    <= `TRK_CTRL_RESET;
			flood_q   <= `TRK_FLOOD_RESET;
			pwd_lo_q  <= `TRK_PWD_LO_RESET;
			pwd_hi_q  <= `TRK_PWD_HI_RESET;
			officer_q <= `TRK_OFFICER_RESET;
			crypto_q  <= `TRK_CRYPTO_RESET;
			mot_to_q  <= `TRK_MOTION_RESET;
			id_len_q  <= 6'h00;
			crypto_err_q <= 1'b0;
		end else if (wr) begin
			unique case (paddr_i)
				`TRK_CTRL_OFF:    ctrl_q <= pwdata_i;
				`TRK_FLOOD_OFF:   flood_q <= pwdata_i;
				`TRK_PWD_LO_OFF:  if (pwd_print) pwd_lo_q <= pwdata_i;
				`TRK_PWD_HI_OFF:  if (pwd_print) pwd_hi_q <= pwdata_i;
				`TRK_OFFICER_OFF: officer_q <= pwdata_i;
				`TRK_CRYPTO_OFF: begin
					if (officer_q != `TRK_OFFICER_RESET) begin
						crypto_q <= pwdata_i;
						crypto_err_q <= 1'b0;
					end else begin
						crypto_err_q <= 1'b1;
					end
				end
				`TRK_EVENT_OFF: begin
					// Escape in the wake window drops back to command mode
					if (esc && awake_q && mode_q != TRK_MODE_EMERG)
						ctrl_q[`TRK_CTRL_CMD_MODE] <= 1'b1;
				end
				`TRK_MOTION_OFF:  mot_to_q <= pwdata_i;
				`TRK_ID_LEN_OFF:  if (pwdata_i <= {26'h0, `TRK_ID_MAX}) id_len_q <= pwdata_i[5:0];
				default: ;
			endcase
		end
	end

	// Power button: toggle on release; supply-up always powers on, since reset clears the wait bit
	// While asleep in tracking a press only opens the wake window
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on_q <= 1'b0;
			btn_q <= 1'b0;
			started_q <= 1'b0;
		end else begin
			btn_q <= power_button_i;
			started_q <= 1'b1;
			if (!started_q) begin
				on_q <= !ctrl_q[`TRK_CTRL_WAIT_BTN];
			end else if (btn_q && !power_button_i && !(tracking && !awake_q)) begin
				on_q <= !on_q;
			end
		end
	end

	// Wake window while asleep between reports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			awake_q <= 1'b0;
			awake_cnt_q <= 32'h0000_0000;
		end else if (tracking && !report_req_i && btn_q && !power_button_i && !awake_q) begin
			awake_q <= 1'b1;
			awake_cnt_q <= AWAKE_CYC - 1;
		end else if (awake_q) begin
			if (awake_cnt_q == 32'h0000_0000) awake_q <= 1'b0;
			else awake_cnt_q <= awake_cnt_q - 32'h0000_0001;
		end
	end

	// Tracking mode machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= TRK_MODE_NORMAL;
			flood_cnt_q <= 8'h00;
			attempt_q <= 1'b0;
			interval_q <= 1'b0;
		end else if (!tracking) begin
			mode_q <= TRK_MODE_NORMAL;
			attempt_q <= 1'b0;
			interval_q <= 1'b0;
		end else begin
			if (tx_done) attempt_q <= 1'b1;
			if (tx_done && flood_cnt_q != 8'h00) flood_cnt_q <= flood_cnt_q - 8'h01;
			if (tx_done && flood_cnt_q == 8'h01) interval_q <= 1'b1;
			unique case (mode_q)
				TRK_MODE_NORMAL: begin
					if (emerg_in) begin
						mode_q <= TRK_MODE_EMERG;
						flood_cnt_q <= flood_q[7:0];
						attempt_q <= 1'b0;
						interval_q <= flood_q[7:0] == 8'h00;
					end else if (test_input_pin_i) begin
						mode_q <= TRK_MODE_TEST;
						flood_cnt_q <= flood_q[15:8];
						attempt_q <= 1'b0;
						interval_q <= flood_q[15:8] == 8'h00;
					end
				end
				TRK_MODE_EMERG: begin
					// Escape has no effect here
					if (ev_wr && pwdata_i[`TRK_EV_EXIT] && !emerg_in && (attempt_q || tx_done))
						mode_q <= TRK_MODE_NORMAL;
				end
				TRK_MODE_TEST: begin
					if (emerg_in) begin
						mode_q <= TRK_MODE_EMERG;
						flood_cnt_q <= flood_q[7:0];
						attempt_q <= 1'b0;
						interval_q <= flood_q[7:0] == 8'h00;
					end else if ((ev_wr && pwdata_i[`TRK_EV_EXIT]) || esc) begin
						mode_q <= TRK_MODE_NORMAL;
					end
				end
			endcase
		end
	end

	// Report dispatch and log
	// The log follows the request, so blocked reports are still kept
	wire send_ok = report_req_i && tracking && !(ctrl_q[`TRK_CTRL_BLOCK] && !fix_i.valid);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			report_send_o <= 1'b0;
			report_emerg_flag_o <= 1'b0;
			log_write_o <= 1'b0;
			log_ptr_q <= '0;
		end else begin
			report_send_o <= send_ok;
			report_emerg_flag_o <= send_ok && mode_q == TRK_MODE_EMERG;
			log_write_o <= report_req_i && tracking && ctrl_q[`TRK_CTRL_LOG_EN];
			if (report_req_i && tracking && ctrl_q[`TRK_CTRL_LOG_EN])
				log_ptr_q <= (log_ptr_q == LW'(LOG_DEPTH - 1)) ? '0 : log_ptr_q + 1'b1;
		end
	end
	assign log_addr_o = 8'(log_ptr_q);

	// Motion persistence
	// Any gap restarts the count, so a single bump never reaches the time-out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mot_cnt_q <= 32'h0000_0000;
			motion_o <= 1'b0;
		end else if (!ctrl_q[`TRK_CTRL_MOT_EN] || !motion_raw_i) begin
			mot_cnt_q <= 32'h0000_0000;
			motion_o <= 1'b0;
		end else if (mot_cnt_q >= mot_to_q) begin
			motion_o <= 1'b1;
		end else begin
			mot_cnt_q <= mot_cnt_q + 32'h0000_0001;
		end
	end

	// Transfer history
	// Last outcome plus any success since reset chooses solid or blink for tracking; command blinks on a clean send after an error
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ok_ever_q <= 1'b0;
			last_ok_q <= 1'b0;
			xfer_seen_q <= 1'b0;
			cmd_err_q <= 1'b0;
			cmd_last_ok_q <= 1'b0;
			cmd_seen_q <= 1'b0;
			cmd_blink_q <= 1'b0;
		end else begin
			if (!tracking) xfer_seen_q <= 1'b0;
			else if (tx_done) begin
				xfer_seen_q <= 1'b1;
				last_ok_q <= tx_ok && fix_i.valid;
				if (tx_ok && fix_i.valid) ok_ever_q <= 1'b1;
			end
			if (!(on_q && ctrl_q[`TRK_CTRL_CMD_MODE])) cmd_seen_q <= 1'b0;
			else if (tx_done) begin
				cmd_seen_q <= 1'b1;
				cmd_last_ok_q <= !pwdata_i[`TRK_EV_CMD_ERR] && tx_ok;
				cmd_blink_q <= cmd_err_q && !pwdata_i[`TRK_EV_CMD_ERR] && tx_ok;
				cmd_err_q <= pwdata_i[`TRK_EV_CMD_ERR] || !tx_ok;
			end
		end
	end

	// Shared blink
	// One counter for every light keeps all blinking in phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == BLINK_CYC - 1) begin
			blink_cnt_q <= 32'h0000_0000;
			blink_q <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
		end
	end

	// Indicators and power outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_o <= '0;
			gps_power_o <= 1'b0;
			dev_on_o <= 1'b0;
		end else begin
			dev_on_o <= on_q;
			gps_power_o <= on_q && (report_req_i || ctrl_q[`TRK_CTRL_GPS_ON]);
			if (!ctrl_q[`TRK_CTRL_LED_EN] || !on_q) begin
				led_o <= '0;
			end else begin
				led_o.power <= 1'b1;
				led_o.gps <= fix_i.valid || (fix_i.two_d && blink_q);
				led_o.sat <= fix_i.bars >= 3'h3 || (is_blink_bars(fix_i.bars) && blink_q);
				led_o.emerg <= emerg_in || mode_q == TRK_MODE_EMERG;
				if (ctrl_q[`TRK_CTRL_CMD_MODE])
					led_o.xfer <= cmd_seen_q && (cmd_blink_q ? blink_q : cmd_last_ok_q);
				else
					led_o.xfer <= xfer_seen_q && (last_ok_q || (ok_ever_q && blink_q));
			end
		end
	end

	// APB slave: one wait-free access phase
	// Writes land at the access edge, so ready never has to stretch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && paddr_i > `TRK_ID_LEN_OFF;
			if (psel_i && !penable_i && !pwrite_i) begin
				unique case (paddr_i)
					`TRK_CTRL_OFF:    prdata_o <= ctrl_q;
					`TRK_FLOOD_OFF:   prdata_o <= flood_q;
					`TRK_STATUS_OFF:  prdata_o <= {22'h0, crypto_err_q, awake_q, interval_q,
						attempt_q, motion_o, on_q, flood_cnt_q[1:0], mode_q};
					`TRK_PWD_LO_OFF:  prdata_o <= pwd_lo_q;
					`TRK_PWD_HI_OFF:  prdata_o <= pwd_hi_q;
					`TRK_CRYPTO_OFF:  prdata_o <= crypto_q;
					`TRK_MOTION_OFF:  prdata_o <= mot_to_q;
					`TRK_ID_LEN_OFF:  prdata_o <= {26'h0, id_len_q};
					default:          prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

`default_nettype wire

// ===== trk_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "trk_defs.svh"
module trk_ctrl_sva
	import trk_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        emerg_button_i,
	input wire logic        emergency_input_pin_i,
	input wire trk_fix_t    fix_i,
	input wire logic        report_send_o,
	input wire logic        report_emerg_flag_o,
	input wire logic        dev_on_o,
	input wire trk_led_t    led_o
);
	logic led_q;
	logic blk_q;
	wire  ctl_wr = psel_i && penable_i && pwrite_i && pready_o && paddr_i == `TRK_CTRL_OFF;
	// Shadow of the control bits, so the checks need no view inside the block
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_q <= 1'b1;
			blk_q <= 1'b0;
		end else if (ctl_wr) begin
			led_q <= pwdata_i[`TRK_CTRL_LED_EN];
			blk_q <= pwdata_i[`TRK_CTRL_BLOCK];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready one cycle after setup");
	unmapped_err_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i > 12'h024
		|=> pslverr_o && prdata_o == 32'h0) else $error("unmapped read not refused");
	flag_send_a: assert property (report_emerg_flag_o |-> report_send_o)
		else $error("emergency flag without a report");
	block_fix_a: assert property (report_send_o && $past(blk_q) |-> $past(fix_i.valid))
		else $error("report sent without a valid fix while blocking");
	emerg_led_a: assert property ((led_q && dev_on_o &&
		(emerg_button_i || emergency_input_pin_i))[*3] |-> led_o.emerg)
		else $error("emergency light dark");
	gps_led_a: assert property ((fix_i.valid && led_q && dev_on_o)[*3] |-> led_o.gps)
		else $error("fix light not solid with valid fix");
	sat_led_a: assert property ((fix_i.bars inside {[3'd3:3'd5]} && led_q && dev_on_o)[*3]
		|-> led_o.sat) else $error("signal light not solid at strong signal");
	indicator_enable_cmd_off_a: assert property ((!led_q)[*3] |-> led_o == '0)
		else $error("light on while lights disabled");
	cover property (report_emerg_flag_o);
	cover property (pslverr_o);
	cover property (led_q && led_o.emerg);
endmodule
bind trk_ctrl trk_ctrl_sva u_sva (
	.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
	.pready_o, .pslverr_o, .emerg_button_i, .emergency_input_pin_i, .fix_i,
	.report_send_o, .report_emerg_flag_o, .dev_on_o, .led_o
);
`default_nettype wire

// ===== trk_user_model.sv
`timescale 1ns/1ps
`default_nettype none
module trk_user_model
	import trk_pkg::*;
(
	input  wire logic clk_i,
	output logic      emerg_button_o,
	output logic      emerg_pin_o,
	output logic      test_pin_o,
	output logic      power_button_o,
	output logic      motion_o,
	output logic      report_req_o,
	output trk_fix_t  fix_o
);
	initial begin
		{emerg_button_o, emerg_pin_o, test_pin_o, power_button_o, motion_o} = '0;
		report_req_o = 1'b0;
		fix_o = '{valid: 1'b1, two_d: 1'b0, bars: 3'd5};
	end
	task automatic pins(input logic eb, input logic ep, input logic tp);
		@(posedge clk_i);
		emerg_button_o <= eb;
		emerg_pin_o <= ep;
		test_pin_o <= tp;
	endtask
	// Press is held a few cycles; the action belongs to the release
	task automatic tap_power();
		@(posedge clk_i);
		power_button_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		power_button_o <= 1'b0;
	endtask
	task automatic motion(input logic m);
		@(posedge clk_i);
		motion_o <= m;
	endtask
	// The fix is set with the request and left as is, so it qualifies the whole cycle
	task automatic report(input trk_fix_t f);
		@(posedge clk_i);
		fix_o <= f;
		report_req_o <= 1'b1;
		@(posedge clk_i);
		report_req_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tracker_mode_and_status_indicator_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "trk_defs.svh"
module tracker_mode_and_status_indicator_bench
	import trk_pkg::*;
();
	localparam trk_fix_t fix_ok = '{valid: 1'b1, two_d: 1'b0, bars: 3'd5};
	localparam trk_fix_t fix_bad = '{valid: 1'b0, two_d: 1'b0, bars: 3'd5};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rerr, dev_on_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rdata;
	logic        emerg_button_i, emergency_input_pin_i, test_input_pin_i, power_button_i;
	logic        motion_raw_i, report_req_i, report_send_o, report_emerg_flag_o;
	logic        log_write_o, gps_power_o, motion_o;
	logic [7:0]  log_addr_o;
	trk_fix_t    fix_i;
	trk_led_t    led_o;
	int          mismatches = 0;
	int          num_checks = 0;
	always #12.5 clk_i = ~clk_i;
	trk_ctrl #(.AWAKE_CYC(100), .BLINK_CYC(4), .LOG_DEPTH(4)) u_dut (
		.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .emerg_button_i, .emergency_input_pin_i, .test_input_pin_i,
		.power_button_i, .motion_raw_i, .report_req_i, .fix_i, .report_send_o,
		.report_emerg_flag_o, .log_write_o, .log_addr_o, .gps_power_o, .dev_on_o,
		.motion_o, .led_o
	);
	trk_user_model u_usr (
		.clk_i, .emerg_button_o(emerg_button_i), .emerg_pin_o(emergency_input_pin_i),
		.test_pin_o(test_input_pin_i), .power_button_o(power_button_i),
		.motion_o(motion_raw_i), .report_req_o(report_req_i), .fix_o(fix_i)
	);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		chkb("pready", 1'b1, pready_o);
		rdata = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rdata);
	endtask
	task automatic ev(input int b);
		apb(1'b1, `TRK_EVENT_OFF, 32'h1 << b);
	endtask
	task automatic mode_is(input trk_mode_t m);
		apb(1'b0, `TRK_STATUS_OFF, 32'h0);
		chk("mode", {30'h0, m}, {30'h0, rdata[1:0]});
	endtask
	task automatic rep(input trk_fix_t f, input logic es, input logic ef);
		logic s;
		logic g;
		s = 1'b0;
		g = 1'b0;
		u_usr.report(f);
		repeat (4) begin
			#1;
			if (report_send_o === 1'b1) begin
				s = 1'b1;
				g = report_emerg_flag_o;
			end
			@(posedge clk_i);
		end
		chkb("send", es, s);
		chkb("flag", ef, g);
	endtask
	task automatic t_regs();
		rdc(`TRK_CTRL_OFF, `TRK_CTRL_RESET, "ctrl");
		rdc(`TRK_PWD_LO_OFF, `TRK_PWD_LO_RESET, "pwd_lo");
		rdc(`TRK_PWD_HI_OFF, `TRK_PWD_HI_RESET, "pwd_hi");
		apb(1'b1, `TRK_PWD_LO_OFF, 32'h3132_0A34);
		rdc(`TRK_PWD_LO_OFF, `TRK_PWD_LO_RESET, "pwd_unprintable");
		apb(1'b1, `TRK_ID_LEN_OFF, 32'h0000_0032);
		apb(1'b1, `TRK_ID_LEN_OFF, 32'h0000_0033);
		rdc(`TRK_ID_LEN_OFF, 32'h0000_0032, "id_len");
		rdc(12'h028, 32'h0, "unmapped");
		chkb("slverr", 1'b1, rerr);
		$display("registers done");
	endtask
	task automatic t_power();
		chkb("on_at_supply", 1'b1, dev_on_o);
		u_usr.tap_power();
		repeat (4) @(posedge clk_i);
		chkb("asleep_press_keeps_on", 1'b1, dev_on_o);
		apb(1'b0, `TRK_STATUS_OFF, 32'h0);
		chkb("wake_window", 1'b1, rdata[8]);
		ev(`TRK_EV_ESC);
		rdc(`TRK_CTRL_OFF, 32'h0000_0041, "escape_exits_tracking");
		for (int i = 0; i < 2; i++) begin
			u_usr.tap_power();
			repeat (4) @(posedge clk_i);
			chkb("power_toggle", i[0], dev_on_o);
		end
		apb(1'b1, `TRK_CTRL_OFF, `TRK_CTRL_RESET);
		$display("power button done");
	endtask
	task automatic t_emerg();
		for (int i = 0; i < 2; i++) begin
			u_usr.pins(i == 0, i == 1, 1'b0);
			repeat (4) @(posedge clk_i);
			mode_is(TRK_MODE_EMERG);
			chkb("emerg_led", 1'b1, led_o.emerg);
			chkb("emerg_flooding", 1'b0, rdata[7]);
			rep(fix_ok, 1'b1, 1'b1);
			u_usr.pins(1'b0, 1'b0, 1'b0);
			ev(`TRK_EV_ESC);
			ev(`TRK_EV_EXIT);
			mode_is(TRK_MODE_EMERG);
			ev(`TRK_EV_TX_DONE);
			ev(`TRK_EV_EXIT);
			mode_is(TRK_MODE_NORMAL);
			chkb("emerg_interval", 1'b1, rdata[7]);
		end
		$display("emergency done");
	endtask
	task automatic t_test();
		apb(1'b1, `TRK_CTRL_OFF, 32'h0000_0011);
		u_usr.pins(1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge clk_i);
		mode_is(TRK_MODE_TEST);
		chkb("test_flooding", 1'b0, rdata[7]);
		rep(fix_bad, 1'b0, 1'b0);
		rep(fix_ok, 1'b1, 1'b0);
		ev(`TRK_EV_TX_DONE);
		mode_is(TRK_MODE_TEST);
		chkb("test_interval", 1'b1, rdata[7]);
		u_usr.pins(1'b0, 1'b0, 1'b0);
		$display("test tracking done");
	endtask
	task automatic t_xfer();
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		apb(1'b1, `TRK_EVENT_OFF, 32'h0000_0006);
		repeat (2) @(posedge clk_i);
		chkb("xfer_solid", 1'b1, led_o.xfer);
		apb(1'b1, `TRK_EVENT_OFF, 32'h0000_0002);
		repeat (10) begin
			@(posedge clk_i);
			if (led_o.xfer === 1'b1) hi++;
			if (led_o.xfer === 1'b0) lo++;
		end
		chkb("xfer_blink", 1'b1, hi > 0 && lo > 0);
		$display("transfer light done");
	endtask
	task automatic t_out();
		chkb("gps_off", 1'b0, gps_power_o);
		apb(1'b1, `TRK_MOTION_OFF, 32'h0000_0008);
		apb(1'b1, `TRK_CTRL_OFF, 32'h0000_002D);
		repeat (2) @(posedge clk_i);
		chkb("gps_always_on", 1'b1, gps_power_o);
		for (int i = 0; i < 5; i++) begin
			u_usr.report(fix_ok);
			#1;
			chkb("log_write", 1'b1, log_write_o);
			@(posedge clk_i);
		end
		chk("log_addr_wrap", 32'h1, {24'h0, log_addr_o});
		u_usr.motion(1'b1);
		repeat (5) @(posedge clk_i);
		chkb("motion_early", 1'b0, motion_o);
		repeat (6) @(posedge clk_i);
		chkb("motion_late", 1'b1, motion_o);
		u_usr.motion(1'b0);
		$display("outputs done");
	endtask
	task automatic t_misc();
		apb(1'b1, `TRK_CRYPTO_OFF, 32'h0000_0001);
		apb(1'b0, `TRK_STATUS_OFF, 32'h0);
		chkb("crypto_refused", 1'b1, rdata[9]);
		rdc(`TRK_CRYPTO_OFF, 32'h0, "crypto_held");
		apb(1'b1, `TRK_OFFICER_OFF, 32'h0000_00A5);
		apb(1'b1, `TRK_CRYPTO_OFF, 32'h0000_0001);
		rdc(`TRK_CRYPTO_OFF, 32'h0000_0001, "crypto_accepted");
		apb(1'b1, `TRK_CTRL_OFF, 32'h0);
		u_usr.pins(1'b0, 1'b1, 1'b0);
		repeat (4) @(posedge clk_i);
		chk("indicator_enable_cmd_off", 32'h0, {27'h0, led_o});
		$display("crypto and lights done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{psel_i, penable_i, pwrite_i} = '0;
		paddr_i = '0;
		pwdata_i = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_regs();
		t_power();
		t_emerg();
		t_test();
		t_xfer();
		t_out();
		t_misc();
		close_out();
	end
	// The whole sequence needs under three hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		close_out();
	end
endmodule
`default_nettype wire
